//--- logic/cad_map.svh
// Address layout and constants for configuration access decoding
`ifndef CAD_MAP_SVH
`define CAD_MAP_SVH
`define CAD_T0_PREFIX    40'h00_00fd_fe
`define CAD_T1_PREFIX    40'h00_00fd_ff
`define CAD_XT0_PREFIX   36'h0_0000_fe0
`define CAD_XT1_PREFIX   36'h0_0000_fe1
`define CAD_PFX_LSB      24
`define CAD_XPFX_LSB     28
`define CAD_UREG_LSB     24
`define CAD_BUS_LSB      16
`define CAD_DEV_LSB      11
`define CAD_FN_LSB       8
`define CAD_REG_LSB      2
`define CAD_SW_BUS_LSB   20
`define CAD_SW_DEV_LSB   15
`define CAD_SW_FN_LSB    12
`define CAD_SW_REG_LSB   2
`define CAD_MAX_UID      5'h1f
`define CAD_HOST_UID     5'h00
`endif

//--- logic/cad_pkg.sv
// Types for configuration access decoding
package cad_pkg;
  typedef enum logic [2:0] {
    CAD_K_NONE = 3'b000,
    CAD_K_T0   = 3'b001,
    CAD_K_T1   = 3'b010,
    CAD_K_XT0  = 3'b011,
    CAD_K_XT1  = 3'b100
  } cad_kind_e;
  typedef enum logic [1:0] {
    CAD_R_OK     = 2'b00,
    CAD_R_MABORT = 2'b01,
    CAD_R_TABORT = 2'b10
  } cad_resp_e;
endpackage

//--- logic/cad_link_if.sv
// Link between host bridge end and chain device end
`timescale 1ns/1ns
`default_nettype none
interface cad_link_if;
  logic        dn_valid;
  logic [63:0] dn_addr;
  logic        dn_write;
  logic        dn_posted;
  logic [3:0]  dn_mask;
  logic [31:0] dn_wdata;
  logic        up_valid;
  logic [63:0] up_addr;
  logic        up_write;
  logic        up_posted;
  logic [31:0] up_wdata;
  logic        rsp_valid;
  cad_pkg::cad_resp_e rsp_code;
  logic [31:0] rsp_rdata;
  logic        hrsp_valid;
  cad_pkg::cad_resp_e hrsp_code;
  logic [31:0] hrsp_rdata;
  modport host (output dn_valid, dn_addr, dn_write, dn_posted, dn_mask, dn_wdata,
                input up_valid, up_addr, up_write, up_posted, up_wdata,
                input rsp_valid, rsp_code, rsp_rdata,
                output hrsp_valid, hrsp_code, hrsp_rdata);
  modport dev (input dn_valid, dn_addr, dn_write, dn_posted, dn_mask, dn_wdata,
               output up_valid, up_addr, up_write, up_posted, up_wdata,
               output rsp_valid, rsp_code, rsp_rdata,
               input hrsp_valid, hrsp_code, hrsp_rdata);
endinterface
`default_nettype wire

//--- logic/cad_addr_dec.sv
// Configuration address classifier and field extractor
`timescale 1ns/1ns
`default_nettype none
`include "cad_map.svh"
module cad_addr_dec (
  input  wire logic [63:0]       addr,
  output cad_pkg::cad_kind_e     kind,
  output logic      [7:0]        bus,
  output logic      [4:0]        dev,
  output logic      [2:0]        fn,
  output logic      [9:0]        regn
);
  logic [39:0] pfx;
  logic [35:0] xpfx;
  assign pfx  = addr[63:`CAD_PFX_LSB];
  assign xpfx = addr[63:`CAD_XPFX_LSB];
  always_comb begin
    if (pfx == `CAD_T0_PREFIX) begin
      kind = cad_pkg::CAD_K_T0;
    end else if (pfx == `CAD_T1_PREFIX) begin
      kind = cad_pkg::CAD_K_T1;
    end else if (xpfx == `CAD_XT0_PREFIX) begin
      kind = cad_pkg::CAD_K_XT0;
    end else if (xpfx == `CAD_XT1_PREFIX) begin
      kind = cad_pkg::CAD_K_XT1;
    end else begin
      kind = cad_pkg::CAD_K_NONE;
    end
  end
  assign bus = addr[`CAD_BUS_LSB+7:`CAD_BUS_LSB];
  assign dev = addr[`CAD_DEV_LSB+4:`CAD_DEV_LSB];
  assign fn  = addr[`CAD_FN_LSB+2:`CAD_FN_LSB];
  assign regn = (kind == cad_pkg::CAD_K_XT0 || kind == cad_pkg::CAD_K_XT1) ?
                {addr[`CAD_UREG_LSB+3:`CAD_UREG_LSB], addr[`CAD_REG_LSB+5:`CAD_REG_LSB]} :
                {4'h0, addr[`CAD_REG_LSB+5:`CAD_REG_LSB]};
endmodule
`default_nettype wire

//--- logic/cad_host_end.sv
// Host bridge end: issues, reflects, accepts or aborts configuration requests
`timescale 1ns/1ns
`default_nettype none
`include "cad_map.svh"
module cad_host_end (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  cad_link_if.host          link,
  input  wire logic         sw_valid,
  output logic              sw_ready,
  input  wire logic         sw_type1,
  input  wire logic         sw_write,
  input  wire logic [27:0]  sw_addr,
  input  wire logic [3:0]   sw_mask,
  input  wire logic [31:0]  sw_wdata,
  output logic              sw_done,
  output cad_pkg::cad_resp_e sw_resp,
  output logic [31:0]       sw_rdata,
  input  wire logic         up_cfg_en,
  input  wire logic [7:0]   local_bus,
  input  wire logic [7:0]   host_bus,
  output logic              loc_valid,
  output logic              loc_write,
  output logic [7:0]        loc_reg,
  output logic [31:0]       loc_wdata,
  input  wire logic [31:0]  loc_rdata
);
  typedef enum logic [1:0] {
    CAD_H_IDLE = 2'b00,
    CAD_H_SW   = 2'b01,
    CAD_H_REFL = 2'b10
  } cad_hstate_e;
  cad_hstate_e        st_q;
  logic               dn_valid_q;
  logic [63:0]        dn_addr_q;
  logic               dn_write_q;
  logic [3:0]         dn_mask_q;
  logic [31:0]        dn_wdata_q;
  logic               hrsp_valid_q;
  cad_pkg::cad_resp_e hrsp_code_q;
  logic [31:0]        hrsp_rdata_q;
  logic               done_q;
  cad_pkg::cad_resp_e resp_q;
  logic [31:0]        rdata_q;
  logic               loc_valid_q;
  logic               loc_write_q;
  logic [7:0]         loc_reg_q;
  logic [31:0]        loc_wdata_q;
  logic               loc_ack_q;
  logic               up_busy_q;
  cad_pkg::cad_kind_e up_kind;
  logic [7:0]         up_bus;
  logic [4:0]         up_dev;
  logic [9:0]         up_reg;
  logic [63:0]        sw_pkt;
  logic               up_cfg;
  cad_addr_dec u_up_dec (
    .addr (link.up_addr),
    .kind (up_kind),
    .bus  (up_bus),
    .dev  (up_dev),
    .fn   (),
    .regn (up_reg)
  );
  // Flat software address to packet
  assign sw_pkt = {sw_type1 ? `CAD_T1_PREFIX : `CAD_T0_PREFIX,
                   sw_addr[`CAD_SW_BUS_LSB+7:`CAD_SW_BUS_LSB],
                   sw_addr[`CAD_SW_DEV_LSB+4:`CAD_SW_DEV_LSB],
                   sw_addr[`CAD_SW_FN_LSB+2:`CAD_SW_FN_LSB],
                   sw_addr[`CAD_SW_REG_LSB+5:`CAD_SW_REG_LSB], 2'b00};
  assign up_cfg   = link.up_valid && !link.up_posted && up_kind != cad_pkg::CAD_K_NONE &&
                    !up_busy_q;
  assign sw_ready = (st_q == CAD_H_IDLE) && !link.up_valid;
  // One answer per held upstream request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      up_busy_q <= 1'b0;
    end else if (!link.up_valid) begin
      up_busy_q <= 1'b0;
    end else if (up_cfg && st_q == CAD_H_IDLE) begin
      up_busy_q <= 1'b1;
    end
  end
  // Request sequencing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= CAD_H_IDLE;
      dn_valid_q <= 1'b0;
      dn_addr_q  <= 64'h0;
      dn_write_q <= 1'b0;
      dn_mask_q  <= 4'h0;
      dn_wdata_q <= 32'h0;
    end else begin
      dn_valid_q <= 1'b0;
      unique case (st_q)
        CAD_H_IDLE: begin
          if (up_cfg && up_cfg_en && (up_kind == cad_pkg::CAD_K_T1 ||
              up_kind == cad_pkg::CAD_K_XT1) && up_bus == local_bus) begin
            st_q       <= CAD_H_REFL;
            dn_valid_q <= 1'b1;
            dn_addr_q  <= {up_kind == cad_pkg::CAD_K_T1 ? `CAD_T0_PREFIX :
                           {`CAD_XT0_PREFIX, link.up_addr[27:24]},
                           link.up_addr[23:0]};
            dn_write_q <= link.up_write;
            dn_mask_q  <= 4'hf;
            dn_wdata_q <= link.up_wdata;
          end else if (sw_valid && sw_ready) begin
            st_q       <= CAD_H_SW;
            dn_valid_q <= 1'b1;
            dn_addr_q  <= sw_pkt;
            dn_write_q <= sw_write;
            dn_mask_q  <= sw_mask;
            dn_wdata_q <= sw_wdata;
          end
        end
        CAD_H_SW, CAD_H_REFL: begin
          if (link.rsp_valid) begin
            st_q <= CAD_H_IDLE;
          end
        end
        default: st_q <= CAD_H_IDLE;
      endcase
    end
  end
  // Software completion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_q  <= 1'b0;
      resp_q  <= cad_pkg::CAD_R_OK;
      rdata_q <= 32'h0;
    end else begin
      done_q <= (st_q == CAD_H_SW) && link.rsp_valid;
      if ((st_q == CAD_H_SW) && link.rsp_valid) begin
        resp_q  <= link.rsp_code;
        rdata_q <= link.rsp_rdata;
      end
    end
  end
  // Upstream answers: reflect result, local service, or abort
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrsp_valid_q <= 1'b0;
      hrsp_code_q  <= cad_pkg::CAD_R_OK;
      hrsp_rdata_q <= 32'h0;
      loc_valid_q  <= 1'b0;
      loc_write_q  <= 1'b0;
      loc_reg_q    <= 8'h0;
      loc_wdata_q  <= 32'h0;
      loc_ack_q    <= 1'b0;
    end else begin
      hrsp_valid_q <= 1'b0;
      loc_valid_q  <= 1'b0;
      loc_ack_q    <= loc_valid_q && !loc_write_q;
      if ((st_q == CAD_H_REFL) && link.rsp_valid) begin
        hrsp_valid_q <= 1'b1;
        hrsp_code_q  <= link.rsp_code;
        hrsp_rdata_q <= link.rsp_rdata;
      end else if (loc_ack_q) begin
        hrsp_valid_q <= 1'b1;
        hrsp_code_q  <= cad_pkg::CAD_R_OK;
        hrsp_rdata_q <= loc_rdata;
      end else if (st_q == CAD_H_IDLE && up_cfg) begin
        if (!up_cfg_en || up_kind == cad_pkg::CAD_K_T0 || up_kind == cad_pkg::CAD_K_XT0) begin
          hrsp_valid_q <= 1'b1;
          hrsp_code_q  <= cad_pkg::CAD_R_TABORT;
        end else if (up_bus == host_bus && up_bus != local_bus) begin
          loc_valid_q <= 1'b1;
          loc_write_q <= link.up_write;
          loc_reg_q   <= up_reg[7:0];
          loc_wdata_q <= link.up_wdata;
          if (link.up_write) begin
            hrsp_valid_q <= 1'b1;
            hrsp_code_q  <= cad_pkg::CAD_R_OK;
          end
        end else if (up_bus != local_bus) begin
          hrsp_valid_q <= 1'b1;
          hrsp_code_q  <= cad_pkg::CAD_R_MABORT;
        end
      end
    end
  end
  assign link.dn_valid   = dn_valid_q;
  assign link.dn_addr    = dn_addr_q;
  assign link.dn_write   = dn_write_q;
  assign link.dn_posted  = 1'b0;
  assign link.dn_mask    = dn_mask_q;
  assign link.dn_wdata   = dn_wdata_q;
  assign link.hrsp_valid = hrsp_valid_q;
  assign link.hrsp_code  = hrsp_code_q;
  assign link.hrsp_rdata = hrsp_rdata_q;
  assign sw_done   = done_q;
  assign sw_resp   = resp_q;
  assign sw_rdata  = rdata_q;
  assign loc_valid = loc_valid_q;
  assign loc_write = loc_write_q;
  assign loc_reg   = loc_reg_q;
  assign loc_wdata = loc_wdata_q;
endmodule
`default_nettype wire

//--- logic/cad_dev_end.sv
// Chain device end: claims configuration requests by unit identifier
`timescale 1ns/1ns
`default_nettype none
`include "cad_map.svh"
module cad_dev_end (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  cad_link_if.dev           link,
  input  wire logic [4:0]   base_uid,
  input  wire logic [4:0]   uid_count,
  input  wire logic [31:0]  dev_impl,
  input  wire logic [7:0]   fn_impl,
  input  wire logic         dual_host,
  input  wire logic [4:0]   host_dev,
  output logic              cfg_valid,
  output logic              cfg_write,
  output logic [4:0]        cfg_dev,
  output logic [2:0]        cfg_fn,
  output logic [9:0]        cfg_reg,
  output logic [3:0]        cfg_mask,
  output logic [31:0]       cfg_wdata,
  input  wire logic [31:0]  cfg_rdata,
  output logic              msg_valid,
  output logic [63:0]       msg_addr,
  output logic [31:0]       msg_data,
  input  wire logic         p2p_valid,
  input  wire logic [63:0]  p2p_addr,
  input  wire logic         p2p_write,
  input  wire logic [31:0]  p2p_wdata,
  output logic              p2p_done,
  output cad_pkg::cad_resp_e p2p_resp,
  output logic [31:0]       p2p_rdata
);
  cad_pkg::cad_kind_e kind;
  logic [7:0]         bus;
  logic [4:0]         dev;
  logic [2:0]         fn;
  logic [9:0]         regn;
  logic               own;
  logic               claim;
  logic [5:0]         uid_top;
  logic               cfg_valid_q;
  logic               cfg_write_q;
  logic [4:0]         cfg_dev_q;
  logic [2:0]         cfg_fn_q;
  logic [9:0]         cfg_reg_q;
  logic [3:0]         cfg_mask_q;
  logic [31:0]        cfg_wdata_q;
  logic               rd_pend_q;
  logic               rsp_valid_q;
  cad_pkg::cad_resp_e rsp_code_q;
  logic [31:0]        rsp_rdata_q;
  logic               msg_valid_q;
  logic [63:0]        msg_addr_q;
  logic [31:0]        msg_data_q;
  logic               p2p_done_q;
  cad_pkg::cad_resp_e p2p_resp_q;
  logic [31:0]        p2p_rdata_q;
  cad_addr_dec u_dn_dec (
    .addr (link.dn_addr),
    .kind (kind),
    .bus  (bus),
    .dev  (dev),
    .fn   (fn),
    .regn (regn)
  );
  assign uid_top = {1'b0, base_uid} + {1'b0, uid_count};
  // Ownership by unit identifier range and implemented spaces, or by host_dev when dual_host is set; device 0 is never owned
  assign own = (dual_host ? (dev == host_dev) :
               (({1'b0, dev} >= {1'b0, base_uid}) && ({1'b0, dev} < uid_top) &&
                (dev_impl[dev] || dev == base_uid))) &&
               dev != `CAD_HOST_UID;
  assign claim = link.dn_valid && !link.dn_posted &&
                 (kind == cad_pkg::CAD_K_T0 || kind == cad_pkg::CAD_K_XT0) &&
                 own && (fn_impl[fn] || fn == 3'h0);
  // Local configuration access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_valid_q <= 1'b0;
      cfg_write_q <= 1'b0;
      cfg_dev_q   <= 5'h0;
      cfg_fn_q    <= 3'h0;
      cfg_reg_q   <= 10'h0;
      cfg_mask_q  <= 4'h0;
      cfg_wdata_q <= 32'h0;
      rd_pend_q   <= 1'b0;
    end else begin
      cfg_valid_q <= claim;
      rd_pend_q   <= claim && !link.dn_write;
      if (claim) begin
        cfg_write_q <= link.dn_write;
        cfg_dev_q   <= dev;
        cfg_fn_q    <= fn;
        cfg_reg_q   <= regn;
        cfg_mask_q  <= link.dn_mask;
        cfg_wdata_q <= link.dn_wdata;
      end
    end
  end
  // Response toward host
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_code_q  <= cad_pkg::CAD_R_OK;
      rsp_rdata_q <= 32'h0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (rd_pend_q) begin
        rsp_valid_q <= 1'b1;
        rsp_code_q  <= cad_pkg::CAD_R_OK;
        rsp_rdata_q <= cfg_rdata;
      end else if (claim && link.dn_write) begin
        rsp_valid_q <= 1'b1;
        rsp_code_q  <= cad_pkg::CAD_R_OK;
      end else if (link.dn_valid && !link.dn_posted && !claim) begin
        rsp_valid_q <= 1'b1;
        rsp_code_q  <= cad_pkg::CAD_R_MABORT;
        rsp_rdata_q <= 32'h0;
      end
    end
  end
  // Posted extended requests carry device messages
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      msg_valid_q <= 1'b0;
      msg_addr_q  <= 64'h0;
      msg_data_q  <= 32'h0;
    end else begin
      msg_valid_q <= link.dn_valid && link.dn_posted &&
                     (kind == cad_pkg::CAD_K_XT0 || kind == cad_pkg::CAD_K_XT1);
      if (link.dn_valid && link.dn_posted) begin
        msg_addr_q <= link.dn_addr;
        msg_data_q <= link.dn_wdata;
      end
    end
  end
  // Peer-to-peer upstream completion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      p2p_done_q  <= 1'b0;
      p2p_resp_q  <= cad_pkg::CAD_R_OK;
      p2p_rdata_q <= 32'h0;
    end else begin
      p2p_done_q <= link.hrsp_valid;
      if (link.hrsp_valid) begin
        p2p_resp_q  <= link.hrsp_code;
        p2p_rdata_q <= link.hrsp_rdata;
      end
    end
  end
  assign link.up_valid  = p2p_valid;
  assign link.up_addr   = p2p_addr;
  assign link.up_write  = p2p_write;
  assign link.up_posted = 1'b0;
  assign link.up_wdata  = p2p_wdata;
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_code  = rsp_code_q;
  assign link.rsp_rdata = rsp_rdata_q;
  assign cfg_valid = cfg_valid_q;
  assign cfg_write = cfg_write_q;
  assign cfg_dev   = cfg_dev_q;
  assign cfg_fn    = cfg_fn_q;
  assign cfg_reg   = cfg_reg_q;
  assign cfg_mask  = cfg_mask_q;
  assign cfg_wdata = cfg_wdata_q;
  assign msg_valid = msg_valid_q;
  assign msg_addr  = msg_addr_q;
  assign msg_data  = msg_data_q;
  assign p2p_done  = p2p_done_q;
  assign p2p_resp  = p2p_resp_q;
  assign p2p_rdata = p2p_rdata_q;
endmodule
`default_nettype wire

//--- tb/cad_link_sva.sv
// Protocol checker for the configuration link between the two ends
`timescale 1ns/1ns
`default_nettype none
`include "cad_map.svh"
module cad_link_sva (
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic               dn_valid,
  input wire logic [63:0]        dn_addr,
  input wire logic               dn_write,
  input wire logic               dn_posted,
  input wire logic               rsp_valid,
  input var  cad_pkg::cad_resp_e rsp_code,
  input wire logic               up_valid,
  input wire logic [63:0]        up_addr,
  input wire logic               up_posted,
  input wire logic               hrsp_valid,
  input var  cad_pkg::cad_resp_e hrsp_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_DN_NONPOSTED: assert property (dn_valid |-> !dn_posted)
    else $error("downstream request marked posted");
  AST_DN_PREFIX: assert property (dn_valid |-> (dn_addr[63:24] == `CAD_T0_PREFIX
      || dn_addr[63:24] == `CAD_T1_PREFIX || dn_addr[63:28] == `CAD_XT0_PREFIX))
    else $error("downstream address prefix is not a configuration prefix");
  AST_DN_SINGLE: assert property (dn_valid |=> !dn_valid [*2])
    else $error("downstream requests too close together");
  AST_DN_ANSWER: assert property (dn_valid |-> ##[1:2] rsp_valid)
    else $error("downstream request left without response");
  AST_WR_ANSWER: assert property (dn_valid && dn_write |=> rsp_valid)
    else $error("write response not one cycle after request");
  AST_DEV0_ABORT: assert property (dn_valid && dn_addr[15:11] == 5'h00 |=>
      rsp_valid && rsp_code == cad_pkg::CAD_R_MABORT)
    else $error("device number zero was claimed");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(dn_valid) || $past(dn_valid, 2))
    else $error("response without a request");
  AST_UP_NONPOSTED: assert property (up_valid |-> !up_posted)
    else $error("upstream request marked posted");
  AST_UP_T0_ABORT: assert property ($rose(up_valid) && up_addr[63:24] == `CAD_T0_PREFIX
      |-> ##[1:3] (hrsp_valid && hrsp_code != cad_pkg::CAD_R_OK))
    else $error("upstream type 0 request not aborted");
  AST_HRSP_CAUSE: assert property (hrsp_valid |-> up_valid)
    else $error("host answer without upstream request");
endmodule
`default_nettype wire

//--- tb/config_access_decode_test.sv
// Self-checking bench joining host end and device end
`timescale 1ns/1ns
`default_nettype none
`include "cad_map.svh"
module config_access_decode_test;
  logic               clock, sys_rst, sw_valid, sw_ready, sw_type1, sw_write, sw_done;
  logic [27:0]        sw_addr;
  logic [3:0]         sw_mask, cfg_mask, mk;
  logic [31:0]        sw_wdata, sw_rdata, loc_wdata, loc_rdata, dev_impl, cfg_wdata, cfg_rdata;
  logic [31:0]        p2p_wdata, p2p_rdata, wd, rd;
  cad_pkg::cad_resp_e sw_resp, p2p_resp;
  logic               up_cfg_en, loc_valid, loc_write, dual_host, cfg_valid, cfg_write;
  logic [7:0]         local_bus, host_bus, loc_reg, fn_impl;
  logic [4:0]         base_uid, uid_count, host_dev, cfg_dev;
  logic [2:0]         cfg_fn;
  logic [9:0]         cfg_reg, cfg_seen;
  logic [63:0]        p2p_addr, dn_seen;
  logic               p2p_valid, p2p_write, p2p_done, seen_dn, seen_loc, seen_cfg;
  int                 err_count, checked, i, seed;
  cad_link_if cad_link_if_i ();
  cad_host_end cad_host_end_i (.clock(clock), .sys_rst(sys_rst), .link(cad_link_if_i.host),
    .sw_valid(sw_valid), .sw_ready(sw_ready), .sw_type1(sw_type1), .sw_write(sw_write),
    .sw_addr(sw_addr), .sw_mask(sw_mask), .sw_wdata(sw_wdata), .sw_done(sw_done),
    .sw_resp(sw_resp), .sw_rdata(sw_rdata), .up_cfg_en(up_cfg_en), .local_bus(local_bus),
    .host_bus(host_bus), .loc_valid(loc_valid), .loc_write(loc_write), .loc_reg(loc_reg),
    .loc_wdata(loc_wdata), .loc_rdata(loc_rdata));
  cad_dev_end cad_dev_end_i (.clock(clock), .sys_rst(sys_rst), .link(cad_link_if_i.dev),
    .base_uid(base_uid), .uid_count(uid_count), .dev_impl(dev_impl), .fn_impl(fn_impl),
    .dual_host(dual_host), .host_dev(host_dev), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_dev(cfg_dev), .cfg_fn(cfg_fn), .cfg_reg(cfg_reg), .cfg_mask(cfg_mask),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .msg_valid(), .msg_addr(), .msg_data(),
    .p2p_valid(p2p_valid), .p2p_addr(p2p_addr), .p2p_write(p2p_write), .p2p_wdata(p2p_wdata),
    .p2p_done(p2p_done), .p2p_resp(p2p_resp), .p2p_rdata(p2p_rdata));
  cad_link_sva cad_link_sva_i (.clock(clock), .sys_rst(sys_rst),
    .dn_valid(cad_link_if_i.dn_valid), .dn_addr(cad_link_if_i.dn_addr),
    .dn_write(cad_link_if_i.dn_write), .dn_posted(cad_link_if_i.dn_posted),
    .rsp_valid(cad_link_if_i.rsp_valid), .rsp_code(cad_link_if_i.rsp_code),
    .up_valid(cad_link_if_i.up_valid), .up_addr(cad_link_if_i.up_addr),
    .up_posted(cad_link_if_i.up_posted), .hrsp_valid(cad_link_if_i.hrsp_valid),
    .hrsp_code(cad_link_if_i.hrsp_code));

  always #2 clock = ~clock;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Expected device answer from the ownership settings
  function automatic cad_pkg::cad_resp_e exp_resp(input logic [4:0] d, input logic [2:0] f);
    logic own;
    own = dual_host ? (d == host_dev) : ({1'b0, d} >= {1'b0, base_uid} &&
      {1'b0, d} < {1'b0, base_uid} + {1'b0, uid_count} && (dev_impl[d] || d == base_uid));
    if (own && d != 5'h00 && (fn_impl[f] || f == 3'h0)) return cad_pkg::CAD_R_OK;
    return cad_pkg::CAD_R_MABORT;
  endfunction

  // Software access through the host end, watched on the link
  task automatic sw_cfg(input logic t1, input logic wr, input logic [4:0] d,
                        input logic [2:0] f, input logic [5:0] r);
    int n;
    cad_pkg::cad_resp_e e;
    e = exp_resp(d, f);
    wd = $urandom;
    rd = $urandom;
    mk = 4'($urandom_range(15, 1));
    seen_cfg = 1'b0;
    n = 0;
    cfg_rdata <= rd;
    sw_type1 <= t1;
    sw_write <= wr;
    sw_addr <= {local_bus, d, f, 4'h0, r, 2'b00};
    sw_mask <= mk;
    sw_wdata <= wd;
    sw_valid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (sw_ready !== 1'b1 && n < 20);
    sw_valid <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (cad_link_if_i.dn_valid === 1'b1) begin
        chk(cad_link_if_i.dn_addr, {t1 ? `CAD_T1_PREFIX : `CAD_T0_PREFIX, local_bus, d, f, r,
          2'b00});
        chk(cad_link_if_i.dn_mask, mk);
      end
      if (cfg_valid === 1'b1) begin
        seen_cfg = 1'b1;
        chk({cfg_dev, cfg_fn, cfg_reg, cfg_write}, {d, f, 4'h0, r, wr});
        chk(cfg_mask, mk);
        if (wr) chk(cfg_wdata, wd);
      end
      if (sw_done === 1'b1) break;
    end
    chk(n < 20, 1);
    if (!t1) begin
      chk(sw_resp, e);
      chk(seen_cfg, e == cad_pkg::CAD_R_OK);
      if (!wr && e == cad_pkg::CAD_R_OK) chk(sw_rdata, rd);
    end
  endtask

  // Upstream request from the device end, held until answered
  task automatic p2p(input logic [63:0] a, input logic wr);
    int n;
    seen_dn = 1'b0;
    seen_loc = 1'b0;
    wd = $urandom;
    rd = $urandom;
    cfg_rdata <= rd;
    loc_rdata <= rd;
    p2p_addr <= a;
    p2p_write <= wr;
    p2p_wdata <= wd;
    p2p_valid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (cad_link_if_i.dn_valid === 1'b1) begin
        seen_dn = 1'b1;
        dn_seen = cad_link_if_i.dn_addr;
      end
      if (cfg_valid === 1'b1) cfg_seen = cfg_reg;
      if (loc_valid === 1'b1) begin
        seen_loc = 1'b1;
        chk(loc_write, wr);
        chk(loc_reg, {2'b00, a[7:2]});
        if (wr) chk(loc_wdata, wd);
      end
      if (p2p_done === 1'b1) break;
    end
    p2p_valid <= 1'b0;
    @(posedge clock);
    chk(n < 20, 1);
  endtask

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {sw_valid, sw_type1, sw_write, p2p_valid, p2p_write, dual_host} = '0;
    {sw_addr, sw_mask, sw_wdata, p2p_addr, p2p_wdata, loc_rdata, cfg_rdata} = '0;
    up_cfg_en = 1'b0;
    local_bus = 8'h02;
    host_bus = 8'h00;
    base_uid = 5'h03;
    uid_count = 5'h03;
    dev_impl = 32'h0000_0028;
    fn_impl = 8'h05;
    host_dev = 5'h07;
    err_count = 0;
    checked = 0;
    seed = $urandom(69478);
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    // Corner devices and functions
    for (i = 0; i < 18; i++) begin
      sw_cfg(1'b0, i[0], 5'({5'h1f, 5'h06, 5'h05, 5'h04, 5'h03, 5'h00} >> (5 * (i / 3))),
        3'(i % 3), 6'h3f);
    end
    for (i = 0; i < 40; i++) begin
      sw_cfg(1'b0, 1'($urandom), 5'($urandom_range(7, 0)), 3'($urandom), 6'($urandom));
    end
    sw_cfg(1'b1, 1'b0, 5'h03, 3'h0, 6'h01);
    dual_host <= 1'b1;
    @(posedge clock);
    sw_cfg(1'b0, 1'b0, 5'h07, 3'h0, 6'h02);
    sw_cfg(1'b0, 1'b0, 5'h03, 3'h0, 6'h02);
    dual_host <= 1'b0;
    @(posedge clock);
    p2p({`CAD_T1_PREFIX, local_bus, 5'h03, 3'h0, 6'h05, 2'b00}, 1'b0);
    chk({seen_dn, p2p_resp}, {1'b0, cad_pkg::CAD_R_TABORT});
    up_cfg_en <= 1'b1;
    p2p({`CAD_T0_PREFIX, local_bus, 5'h03, 3'h0, 6'h05, 2'b00}, 1'b0);
    chk(p2p_resp != cad_pkg::CAD_R_OK && !seen_dn, 1);
    p2p({`CAD_T1_PREFIX, 8'h07, 5'h03, 3'h0, 6'h05, 2'b00}, 1'b1);
    chk({seen_dn, seen_loc, p2p_resp}, {2'b00, cad_pkg::CAD_R_MABORT});
    for (i = 0; i < 4; i++) begin
      p2p({`CAD_T1_PREFIX, i[1] ? host_bus : local_bus, 5'h03, 3'h0, 6'h09, 2'b00}, i[0]);
      chk({seen_dn, seen_loc, p2p_resp}, {!i[1], i[1], cad_pkg::CAD_R_OK});
      if (!i[1]) chk(dn_seen, {`CAD_T0_PREFIX, local_bus, 5'h03, 3'h0, 6'h09, 2'b00});
      if (!i[0]) chk(p2p_rdata, rd);
    end
    p2p({`CAD_XT1_PREFIX, 4'h2, local_bus, 5'h03, 3'h0, 6'h09, 2'b00}, 1'b0);
    chk(dn_seen, {`CAD_XT0_PREFIX, 4'h2, local_bus, 5'h03, 3'h0, 6'h09, 2'b00});
    chk({cfg_seen, p2p_rdata, p2p_resp}, {4'h2, 6'h09, rd, cad_pkg::CAD_R_OK});
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
